// *** src/quad_counter_gate_control.sv ***
// gate control, BCD tallies, event counter and APB registers of a quad counter
// assumes all inputs synchronous to pclk; pulses counted on rising edges
//
// Summary of operation
// - channel 1 tally decides the counting interval
// - interval start opens all four gates together
// - channel 1 reaching preset closes all gates
// - dwell off means no automatic restart, except in limit mode
// - dwell set: wait, clear channels, restart
// - channel 1 counts tenth-second, minute or outside pulses
// - selected channel drives the eight-digit display
// - host-only presettable eight-digit event counter
// - per-cycle mode adds one per interval
// - host can read event and all tallies
// - outside mode counts pulses below 4 kHz
// - limit mode recycles until event equals preset
// - remote enable locks out panel controls except display select
// - host controls all panel functions, dwell only in remote, plus extras
// - each channel has its own gate
// - master gate enables all four channels
// - overflow flag held until channel cleared
// - preset is M times ten to N; M zero disables
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps

module quad_counter_gate_control
    import quad_counter_pkg::*;
#(
    parameter int TENTH_CYC = TENTH_CYCLES,
    parameter int DWELL_CYC = DWELL_STEP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire apb_req_type apb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] count_pulse,
    input wire logic outside_pulse_source,
    input wire logic event_pulse,
    input wire logic master_gate,
    input wire logic [3:0] chan_gate,
    input wire panel_type panel,
    output logic [3:0] chan_gate_open,
    output logic gate_lamp,
    output logic [31:0] display_value,
    output logic [1:0] display_chan,
    output logic [3:0] overflow,
    output logic remote_lamp,
    output logic irq
);

    state_type q;
    state_type d;

    logic wr;
    logic setup;
    logic [5:0] cmd;
    logic local_ok;
    logic start;
    logic stop;
    logic clear;
    logic tenth_tick;
    logic minute_tick;
    logic [3:0] hits;
    logic [3:0] open;
    logic [3:0] ovf_set;
    logic [3:0][32:0] inc;
    logic [32:0] evt_inc;
    logic ev_end;
    logic ev_lim;
    logic [4:0] dwell_eff;
    logic [31:0] target;
    logic [2:0] irq_ev;

    // ripple carry through eight BCD digits; bit 32 is the carry out
    function automatic logic [32:0] bcd_inc(input logic [31:0] v);
        logic [32:0] r;
        logic c;
        r = '0;
        c = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (c && v[4*i +: 4] == 4'h9) begin
                r[4*i +: 4] = 4'h0;
            end else begin
                r[4*i +: 4] = v[4*i +: 4] + {3'h0, c};
                c = 1'b0;
            end
        end
        r[32] = c;
        return r;
    endfunction

    // BCD form of M x 10^N is the digit M placed at decade N
    function automatic logic [31:0] preset_bcd(input logic [3:0] m, input logic [2:0] n);
        return {28'h0, m} << {n, 2'b00};
    endfunction

    function automatic logic hit_addr(input logic [11:0] a);
        return a == CTRL_OFS || a == CMD_OFS || a == STATUS_OFS || a == EVT_PRESET_OFS
            || a == EVENT_OFS || (a >= CHAN_OFS && a < IRQ_STATUS_OFS && a[1:0] == 2'b00)
            || a == IRQ_STATUS_OFS || a == IRQ_MASK_OFS;
    endfunction

    always_comb begin
        d = q;
        wr = apb.psel & apb.penable & apb.pwrite;
        setup = apb.psel & ~apb.penable;
        cmd = (wr && apb.paddr == CMD_OFS) ? apb.pwdata[5:0] : 6'h00;
        local_ok = ~q.remote;
        start = cmd[CMD_START] | (panel.count & local_ok);
        stop = cmd[CMD_STOP] | (panel.stop & local_ok);
        clear = cmd[CMD_CLEAR] | (panel.clear & local_ok);
        dwell_eff = q.remote ? q.dwell : panel.dwell;
        ev_end = 1'b0;
        ev_lim = 1'b0;
        ovf_set = 4'h0;

        // free-running time bases
        tenth_tick = q.tick == 32'(TENTH_CYC - 1);
        minute_tick = tenth_tick && q.tenths == MINUTE_TENTHS - 10'd1;
        d.tick = tenth_tick ? 32'h0 : q.tick + 32'h1;
        if (tenth_tick) begin
            d.tenths = minute_tick ? 10'h0 : q.tenths + 10'h1;
        end

        d.pulse_prev = count_pulse;
        d.src_prev = outside_pulse_source;
        d.evt_prev = event_pulse;
        hits[3:1] = count_pulse & ~q.pulse_prev;
        case (q.tb)
            TB_TENTH: hits[0] = tenth_tick;
            TB_MINUTE: hits[0] = minute_tick;
            TB_OUTSIDE: hits[0] = outside_pulse_source & ~q.src_prev;
            default: hits[0] = 1'b0;
        endcase

        // all four gates follow the one interval state
        open = (q.phase == PH_RUN && master_gate) ? chan_gate : 4'h0;

        // clearing drops the flags first so a same-cycle overflow survives
        if (clear) begin
            d.ovf = 4'h0;
        end
        for (int i = 0; i < 4; i++) begin
            inc[i] = bcd_inc(q.cnt[i]);
            if (open[i] && hits[i]) begin
                d.cnt[i] = inc[i][31:0];
                if (inc[i][32]) begin
                    d.ovf[i] = 1'b1;
                    ovf_set[i] = 1'b1;
                end
            end
        end

        // BCD compares like binary, so >= also ends an interval left past its preset
        target = preset_bcd(q.mult, q.expo);
        if (q.phase == PH_RUN && q.mult != 4'h0 && d.cnt[0] >= target) begin
            ev_end = 1'b1;
        end

        evt_inc = bcd_inc(q.evt);
        if (q.emode == EV_OUTSIDE && event_pulse && !q.evt_prev) begin
            d.evt = evt_inc[31:0];
        end
        if (ev_end && (q.emode == EV_PER_CYCLE || q.emode == EV_LIMIT)) begin
            d.evt = evt_inc[31:0];
            if (q.emode == EV_LIMIT && evt_inc[31:0] == q.evt_pre) begin
                ev_lim = 1'b1;
            end
        end
        if (cmd[CMD_EVT_CLEAR]) begin
            d.evt = 32'h0;
            d.limit_hit = 1'b0;
        end
        // flag set after the clear so a same-cycle limit hit is kept
        if (ev_lim) begin
            d.limit_hit = 1'b1;
        end

        case (q.phase)
            PH_IDLE: begin
                if (start) begin
                    d.phase = PH_RUN;
                    d.limit_hit = 1'b0;
                end
            end
            PH_RUN: begin
                if (stop) begin
                    d.phase = PH_IDLE;
                end else if (ev_end) begin
                    if (ev_lim || (dwell_eff == 5'h0 && q.emode != EV_LIMIT)) begin
                        d.phase = PH_IDLE;
                    end else begin
                        d.phase = PH_DWELL;
                        d.timer = 32'(dwell_eff) * 32'(DWELL_CYC);
                    end
                end
            end
            PH_DWELL: begin
                if (stop) begin
                    d.phase = PH_IDLE;
                end else if (q.timer == 32'h0) begin
                    d.phase = PH_RUN;
                    d.cnt = '0;
                    d.ovf = 4'h0;
                end else begin
                    d.timer = q.timer - 32'h1;
                end
            end
            default: d.phase = PH_IDLE;
        endcase

        if (clear) begin
            d.cnt = '0;
        end

        // panel controls, locked out in remote except display select
        if (panel.select) begin
            d.sel = q.sel + 2'h1;
        end
        if (local_ok) begin
            if (panel.timebase) begin
                d.tb = (q.tb == TB_OUTSIDE) ? TB_TENTH : timebase_type'(q.tb + 2'h1);
            end
            if (panel.mult) begin
                d.mult = (q.mult == MULT_MAX) ? 4'h0 : q.mult + 4'h1;
            end
            if (panel.expo) begin
                d.expo = q.expo + 3'h1;
            end
        end

        // host side, allowed in either mode
        if (cmd[CMD_REMOTE]) begin
            d.remote = 1'b1;
        end
        if (cmd[CMD_LOCAL]) begin
            d.remote = 1'b0;
        end
        if (wr && apb.paddr == CTRL_OFS) begin
            if (apb.pwdata[CTRL_TB_LSB +: 2] != 2'h3) begin
                d.tb = timebase_type'(apb.pwdata[CTRL_TB_LSB +: 2]);
            end
            d.sel = apb.pwdata[CTRL_SEL_LSB +: 2];
            if (apb.pwdata[CTRL_MULT_LSB +: 4] <= MULT_MAX) begin
                d.mult = apb.pwdata[CTRL_MULT_LSB +: 4];
            end
            d.expo = apb.pwdata[CTRL_EXPO_LSB +: 3];
            d.dwell = apb.pwdata[CTRL_DWELL_LSB +: 5];
            d.emode = event_mode_type'(apb.pwdata[CTRL_EMODE_LSB +: 2]);
        end
        if (wr && apb.paddr == EVT_PRESET_OFS) begin
            d.evt_pre = apb.pwdata;
        end
        if (wr && apb.paddr == IRQ_MASK_OFS) begin
            d.irq_mask = apb.pwdata[2:0];
        end

        // write one clears, a new event in the same cycle wins
        irq_ev = {ev_lim, |ovf_set, ev_end};
        d.irq_st = q.irq_st;
        if (wr && apb.paddr == IRQ_STATUS_OFS) begin
            d.irq_st = q.irq_st & ~apb.pwdata[2:0];
        end
        d.irq_st = d.irq_st | irq_ev;

        d.disp = q.cnt[q.sel];

        // read data is captured in the setup cycle so pready needs no wait state
        if (setup) begin
            d.err = ~hit_addr(apb.paddr);
            d.rdata = 32'h0;
            if (apb.paddr == CTRL_OFS) begin
                d.rdata[CTRL_TB_LSB +: 2] = q.tb;
                d.rdata[CTRL_SEL_LSB +: 2] = q.sel;
                d.rdata[CTRL_MULT_LSB +: 4] = q.mult;
                d.rdata[CTRL_EXPO_LSB +: 3] = q.expo;
                d.rdata[CTRL_DWELL_LSB +: 5] = q.dwell;
                d.rdata[CTRL_EMODE_LSB +: 2] = q.emode;
            end else if (apb.paddr == STATUS_OFS) begin
                d.rdata[ST_RUN] = q.phase == PH_RUN;
                d.rdata[ST_DWELL] = q.phase == PH_DWELL;
                d.rdata[ST_OVF_LSB +: 4] = q.ovf;
                d.rdata[ST_REMOTE] = q.remote;
                d.rdata[ST_LIMIT] = q.limit_hit;
            end else if (apb.paddr == EVT_PRESET_OFS) begin
                d.rdata = q.evt_pre;
            end else if (apb.paddr == EVENT_OFS) begin
                d.rdata = q.evt;
            end else if (apb.paddr >= CHAN_OFS && apb.paddr < IRQ_STATUS_OFS) begin
                d.rdata = q.cnt[2'(apb.paddr[11:2] - CHAN_OFS[11:2])];
            end else if (apb.paddr == IRQ_STATUS_OFS) begin
                d.rdata[2:0] = q.irq_st;
            end else if (apb.paddr == IRQ_MASK_OFS) begin
                d.rdata[2:0] = q.irq_mask;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= STATE_RESET;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign prdata = q.rdata;
    assign pready = apb.psel & apb.penable;
    assign pslverr = apb.psel & apb.penable & q.err;
    assign chan_gate_open = open;
    assign gate_lamp = q.phase == PH_RUN && master_gate;
    assign display_value = q.disp;
    assign display_chan = q.sel;
    assign overflow = q.ovf;
    assign remote_lamp = q.remote;
    assign irq = |(q.irq_st & q.irq_mask);

endmodule

// *** src/quad_counter_pkg.sv ***
// constants, register map and carrier types of the quad counter gate control
// assumes a 200 MHz pclk and a 32-bit APB slave with a 12-bit byte address
package quad_counter_pkg;

    localparam longint CLK_PERIOD_NS = 5;
    localparam longint TENTH_SEC_NS = 100_000_000;
    localparam int TENTH_CYCLES = int'(TENTH_SEC_NS / CLK_PERIOD_NS);
    localparam logic [9:0] MINUTE_TENTHS = 10'd600;
    localparam longint DWELL_STEP_NS = 500_000_000;
    localparam int DWELL_STEP_CYCLES = int'(DWELL_STEP_NS / CLK_PERIOD_NS);

    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] CMD_OFS = 12'h004;
    localparam logic [11:0] STATUS_OFS = 12'h008;
    localparam logic [11:0] EVT_PRESET_OFS = 12'h00C;
    localparam logic [11:0] EVENT_OFS = 12'h010;
    localparam logic [11:0] CHAN_OFS = 12'h014;
    localparam logic [11:0] IRQ_STATUS_OFS = 12'h024;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h028;

    localparam int CTRL_TB_LSB = 0;
    localparam int CTRL_SEL_LSB = 2;
    localparam int CTRL_MULT_LSB = 4;
    localparam int CTRL_EXPO_LSB = 8;
    localparam int CTRL_DWELL_LSB = 11;
    localparam int CTRL_EMODE_LSB = 16;

    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_CLEAR = 2;
    localparam int CMD_EVT_CLEAR = 3;
    localparam int CMD_REMOTE = 4;
    localparam int CMD_LOCAL = 5;

    localparam int ST_RUN = 0;
    localparam int ST_DWELL = 1;
    localparam int ST_OVF_LSB = 2;
    localparam int ST_REMOTE = 6;
    localparam int ST_LIMIT = 7;

    localparam int IRQ_END = 0;
    localparam int IRQ_OVF = 1;
    localparam int IRQ_LIMIT = 2;

    localparam logic [3:0] MULT_MAX = 4'h9;
    localparam logic [2:0] EXPO_MAX = 3'h7;

    typedef enum logic [1:0] {TB_TENTH, TB_MINUTE, TB_OUTSIDE} timebase_type;
    typedef enum logic [1:0] {EV_OFF, EV_PER_CYCLE, EV_OUTSIDE, EV_LIMIT} event_mode_type;
    typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_DWELL} phase_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic count;
        logic stop;
        logic clear;
        logic select;
        logic timebase;
        logic mult;
        logic expo;
        logic [4:0] dwell;
    } panel_type;

    typedef struct packed {
        phase_type phase;
        logic [31:0] timer;
        logic [31:0] tick;
        logic [9:0] tenths;
        logic [3:0][31:0] cnt;
        logic [3:0] ovf;
        logic [31:0] evt;
        logic [31:0] evt_pre;
        timebase_type tb;
        logic [1:0] sel;
        logic [3:0] mult;
        logic [2:0] expo;
        logic [4:0] dwell;
        event_mode_type emode;
        logic remote;
        logic limit_hit;
        logic [2:0] irq_st;
        logic [2:0] irq_mask;
        logic [2:0] pulse_prev;
        logic src_prev;
        logic evt_prev;
        logic [31:0] disp;
        logic [31:0] rdata;
        logic err;
    } state_type;

    localparam state_type STATE_RESET = '0;

endpackage

// *** verif/pulse_source.sv ***
// partner: pulse trains for channels 2..4, outside source and event input
// assumes bursts are requested from one process at a time
`timescale 1ns/1ps

module pulse_source (
    input wire logic pclk,
    output logic [4:0] pulses
);
    initial pulses = 5'h00;

    // lines idle low; gap spaces pulses, event line needs it wide
    task automatic burst(input logic [4:0] mask, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            if (i > 0) begin
                repeat (gap) @(posedge pclk);
            end
            @(posedge pclk);
            pulses <= mask;
            @(posedge pclk);
            pulses <= 5'h00;
        end
    endtask
endmodule

// *** verif/quad_counter_gate_control_assertions.sv ***
// port checks of the quad counter gate control
// assumes one pclk domain and the package register offsets
`timescale 1ns/1ps

module quad_counter_checker
    import quad_counter_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire apb_req_type apb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic master_gate,
    input wire logic [3:0] chan_gate,
    input wire panel_type panel,
    input wire logic [3:0] chan_gate_open,
    input wire logic gate_lamp,
    input wire logic [1:0] display_chan,
    input wire logic remote_lamp
);
    logic wr;
    assign wr = clk_en && apb.psel && apb.penable && apb.pwrite;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_start;
        wr && apb.paddr == CMD_OFS && apb.pwdata[CMD_START] && !apb.pwdata[CMD_STOP];
    endsequence
    sequence s_start_gated;
        s_start ##1 master_gate;
    endsequence

    a_start_opens: assert property (s_start_gated |-> gate_lamp && chan_gate_open == chan_gate)
        else $error("gates not opened after start");
    a_gate_and: assert property (chan_gate_open == ({4{gate_lamp}} & chan_gate))
        else $error("channel gate not run and master and own gate");
    a_master_closes: assert property (!master_gate |-> !gate_lamp && chan_gate_open == 4'h0)
        else $error("gate open with master gate low");
    a_stop_closes: assert property (wr && apb.paddr == CMD_OFS && apb.pwdata[CMD_STOP]
        && !apb.pwdata[CMD_START] && !panel.count |=> !gate_lamp)
        else $error("interval still running after stop");
    a_ready_zero: assert property (apb.psel && apb.penable |-> pready)
        else $error("access without ready");
    a_err_access: assert property (pslverr |-> apb.psel && apb.penable && pready)
        else $error("error outside access");
    a_remote_host: assert property ($rose(remote_lamp) |->
        $past(wr && apb.paddr == CMD_OFS && apb.pwdata[CMD_REMOTE]))
        else $error("remote entered without host command");
    a_display_src: assert property ($changed(display_chan) |->
        $past(wr && apb.paddr == CTRL_OFS) || $past(clk_en && panel.select))
        else $error("display channel changed on its own");
endmodule

bind quad_counter_gate_control quad_counter_checker quad_counter_checker_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb(apb), .pready(pready),
    .pslverr(pslverr), .master_gate(master_gate), .chan_gate(chan_gate), .panel(panel),
    .chan_gate_open(chan_gate_open), .gate_lamp(gate_lamp), .display_chan(display_chan),
    .remote_lamp(remote_lamp));

// *** verif/tb.sv ***
// bench: APB host, gate levels and pulse partner around the quad counter
// assumes pulse_source and the bound checker are compiled alongside
`timescale 1ns/1ps

module tb;
    import quad_counter_pkg::*;
    localparam int TENTH = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_type bus = '0;
    panel_type panel = '0;
    logic master_gate = 1'b1;
    logic clk_en = 1'b1;
    logic [1:0] display_chan;
    logic [3:0] overflow;
    logic [3:0] chan_gate = 4'hF;
    logic [4:0] pulses;
    logic [31:0] prdata, display_value, rd;
    logic pready, pslverr, gate_lamp, remote_lamp, irq, err;
    logic [3:0] chan_gate_open;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int t;
    int exp_cnt[4];

    always #2.5 pclk = ~pclk;

    quad_counter_gate_control #(.TENTH_CYC(TENTH), .DWELL_CYC(5))
        quad_counter_gate_control_inst (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb(bus), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_pulse(pulses[2:0]),
        .outside_pulse_source(pulses[3]), .event_pulse(pulses[4]), .master_gate(master_gate),
        .chan_gate(chan_gate), .panel(panel), .chan_gate_open(chan_gate_open),
        .gate_lamp(gate_lamp), .display_value(display_value),
        .display_chan(display_chan), .overflow(overflow), .remote_lamp(remote_lamp),
        .irq(irq));

    pulse_source pulse_source_inst (.pclk(pclk), .pulses(pulses));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            finish_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        bus <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        bus.penable <= 1'b1;
        // no cycle limit here: only the bench timeout ends a stuck access
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk("pready_wait", 32'h1, 32'(n));
        rd = prdata;
        err = pslverr;
        bus <= '0;
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask

    task automatic wait_lamp(input logic v, input int lim);
        // sampled on falling edges, away from the edge that updates the lamp
        t = 0;
        @(negedge pclk);
        while (gate_lamp !== v && t < lim) begin
            @(negedge pclk);
            t++;
        end
        chk("gate_lamp", 32'(v), 32'(gate_lamp));
        @(posedge pclk);
    endtask

    initial begin
        t = $urandom(32'hF5FC);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl", CTRL_OFS, 32'h0);
        rd_chk("status", STATUS_OFS, 32'h0);
        rd_chk("unmapped", 12'h030, 32'h0);
        chk("pslverr", 32'h1, 32'(err));
        xfer(1'b1, CMD_OFS, 32'h1 << CMD_REMOTE);
        repeat (2) @(posedge pclk);
        chk("remote_lamp", 32'h1, 32'(remote_lamp));
        $display("test reset done");

        for (int b = 0; b < 2; b++) begin
            xfer(1'b1, CTRL_OFS, 32'(b) | (32'h1 << CTRL_MULT_LSB));
            xfer(1'b1, CMD_OFS, 32'h5);
            wait_lamp(1'b1, 10);
            wait_lamp(1'b0, 7000);
            chk("span", 32'h1, 32'(t <= (b ? 601 : 2) * TENTH + 5));
            rd_chk("chan1", CHAN_OFS, 32'h1);
        end
        $display("test timebase done");

        // ch1 fed by outside pulses, preset 3, per-cycle events, display ch2
        xfer(1'b1, CTRL_OFS, 32'h2 | (32'h1 << CTRL_SEL_LSB) | (32'h3 << CTRL_MULT_LSB)
            | (32'h1 << CTRL_EMODE_LSB));
        chan_gate <= 4'($urandom) | 4'h1;
        master_gate <= 1'b0;
        xfer(1'b1, CMD_OFS, 32'hD);
        pulse_source_inst.burst(5'h0F, 2, 1);
        rd_chk("masked", CHAN_OFS, 32'h0);
        master_gate <= 1'b1;
        pulse_source_inst.burst(5'h0F, 5, 1);
        wait_lamp(1'b0, 20);
        for (int k = 0; k < 4; k++) begin
            exp_cnt[k] = chan_gate[k] ? 3 : 0;
            rd_chk("tally", CHAN_OFS + 12'(4 * k), 32'(exp_cnt[k]));
        end
        chk("display", 32'(exp_cnt[1]), display_value);
        chk("overflow", 32'h0, 32'(overflow));
        rd_chk("event", EVENT_OFS, 32'h1);
        chk("gate_lamp", 32'h0, 32'(gate_lamp));
        chk("irq", 32'h0, 32'(irq));
        xfer(1'b1, IRQ_MASK_OFS, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h1, 32'(irq));
        xfer(1'b1, IRQ_STATUS_OFS, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h0, 32'(irq));
        panel.count <= 1'b1;
        @(posedge pclk);
        panel.count <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("gate_lamp", 32'h0, 32'(gate_lamp));
        $display("test gating done");

        xfer(1'b1, EVT_PRESET_OFS, 32'h2);
        xfer(1'b1, CTRL_OFS, 32'h2 | (32'h2 << CTRL_MULT_LSB) | (32'h1 << CTRL_DWELL_LSB)
            | (32'h3 << CTRL_EMODE_LSB));
        xfer(1'b1, CMD_OFS, 32'hD);
        pulse_source_inst.burst(5'h0F, 2, 1);
        wait_lamp(1'b0, 20);
        wait_lamp(1'b1, 40);
        // one step of 5 cycles plus the restart edge, less the two starting half cycles
        chk("dwell_span", 32'h5, 32'(t));
        rd_chk("chan1", CHAN_OFS, 32'h0);
        pulse_source_inst.burst(5'h0F, 2, 1);
        repeat (40) @(posedge pclk);
        chk("gate_lamp", 32'h0, 32'(gate_lamp));
        rd_chk("event", EVENT_OFS, 32'h2);
        rd_chk("status", STATUS_OFS, 32'hC0);
        $display("test dwell done");

        xfer(1'b1, CTRL_OFS, 32'h2 << CTRL_EMODE_LSB);
        xfer(1'b1, CMD_OFS, 32'h9);
        pulse_source_inst.burst(5'h10, 2, 50001);
        chk("gate_lamp", 32'h1, 32'(gate_lamp));
        rd_chk("event", EVENT_OFS, 32'h2);
        clk_en <= 1'b0;
        panel.select <= 1'b1;
        @(posedge pclk);
        panel.select <= 1'b0;
        clk_en <= 1'b1;
        @(posedge pclk);
        chk("display_chan", 32'h0, 32'(display_chan));
        panel.select <= 1'b1;
        @(posedge pclk);
        panel.select <= 1'b0;
        @(posedge pclk);
        chk("display_chan", 32'h1, 32'(display_chan));
        xfer(1'b1, CMD_OFS, 32'h1 << CMD_STOP);
        wait_lamp(1'b0, 5);
        $display("test event done");
        finish_test();
    end
endmodule
